// ---- dv/sbcip_checker.sv ----
// Port assertions of the interrupt pulse unit
`timescale 1ns/1ps
module sbcip_checker #(
    parameter int PULSE_UNIT_CYC = 250
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register bus
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic [1:0] o_s_axi_bresp,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic [1:0] o_s_axi_rresp,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // Sources and outputs
    input wire sbcip_pkg::sbcip_analog_type i_analog,
    input wire logic o_interrupt_out_n,
    input wire logic o_irq,
    input wire logic o_can_supply_en
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic aw_bad;
    int low_cnt;
    ////////////////////////////////////////////////////////////
    // Write in flight targets an unmapped word
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_bad <= 1'b0;
        end else if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_bad <= (i_s_axi_awaddr > 8'h10) || (i_s_axi_awaddr[1:0] != 2'h0);
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            low_cnt <= 0;
        end else if (!o_interrupt_out_n) begin
            low_cnt <= low_cnt + 1;
        end else begin
            low_cnt <= 0;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_b_after;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
            |-> ##[1:2] o_s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("no write response");
    property p_b_ready;
        o_s_axi_bvalid && i_s_axi_bready |-> ##[1:2] (o_s_axi_awready && o_s_axi_wready);
    endproperty
    a_b_ready: assert property (p_b_ready) else $error("write channel not reopened");
    property p_r_after;
        i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
    endproperty
    a_r_after: assert property (p_r_after) else $error("no read data");
    property p_r_ready;
        o_s_axi_rvalid && i_s_axi_rready |-> ##[1:2] o_s_axi_arready;
    endproperty
    a_r_ready: assert property (p_r_ready) else $error("read channel not reopened");
    property p_aw_err;
        o_s_axi_bvalid && aw_bad |-> o_s_axi_bresp == 2'h2;
    endproperty
    a_aw_err: assert property (p_aw_err) else $error("unmapped write accepted");
    property p_ar_err;
        i_s_axi_arvalid && o_s_axi_arready && (i_s_axi_araddr > 8'h10)
            |=> o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 32'h0;
    endproperty
    a_ar_err: assert property (p_ar_err) else $error("unmapped read accepted");
    property p_pulse_len;
        $rose(o_interrupt_out_n) |-> low_cnt > 0 && low_cnt % PULSE_UNIT_CYC == 0;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length off");
    property p_pulse_irq;
        $fell(o_interrupt_out_n) |-> o_irq || $past(o_irq);
    endproperty
    a_pulse_irq: assert property (p_pulse_irq) else $error("pulse without unmasked flag");
    property p_can_off;
        $rose(i_analog.can_supply_thermal_shutdown) |-> ##[1:4] !o_can_supply_en;
    endproperty
    a_can_off: assert property (p_can_off) else $error("CAN supply stayed on");
    property p_can_on;
        (!i_analog.can_supply_thermal_shutdown && i_analog.can_tj_cooled) [*5]
            |=> o_can_supply_en;
    endproperty
    a_can_on: assert property (p_can_on) else $error("CAN supply did not restart");
endmodule

bind sbcip_top sbcip_checker #(.PULSE_UNIT_CYC(PULSE_UNIT_CYC)) sbcip_checker_i (.*);

// ---- dv/sbcip_host_model.sv ----
// Host side model: sends serial frames and counts interrupt pulses
`timescale 1ns/1ps
module sbcip_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Interrupt from the device
    input wire logic i_interrupt_out_n,
    // Serial pins
    output logic o_spi_sclk,
    output logic o_chip_select_n,
    output logic o_spi_mosi,
    // Falling edges seen
    output int o_pulse_cnt
);
    logic last_n;
    initial begin
        o_spi_sclk = 1'b0;
        o_chip_select_n = 1'b1;
        o_spi_mosi = 1'b0;
        o_pulse_cnt = 0;
        last_n = 1'b1;
    end
    always @(posedge i_sys_clk) begin
        if (last_n && !i_interrupt_out_n) begin
            o_pulse_cnt <= o_pulse_cnt + 1;
        end
        last_n <= i_interrupt_out_n;
    end
    ////////////////////////////////////////////////////////////
    // Clock stands still outside frames; each level lasts 3 cycles
    task automatic send_frame(input logic [15:0] bits, input int n);
        int i;
        @(posedge i_sys_clk);
        o_chip_select_n <= 1'b0;
        for (i = 0; i < n; i++) begin
            o_spi_mosi <= bits[n - 1 - i];
            repeat (3) @(posedge i_sys_clk);
            o_spi_sclk <= 1'b1;
            repeat (3) @(posedge i_sys_clk);
            o_spi_sclk <= 1'b0;
        end
        repeat (3) @(posedge i_sys_clk);
        o_chip_select_n <= 1'b1;
        o_spi_mosi <= ~o_spi_mosi;
        repeat (8) @(posedge i_sys_clk);
    endtask
endmodule

// ---- dv/sbcip_top_tb.sv ----
// Testbench of the interrupt pulse unit
`timescale 1ns/1ps
module sbcip_top_tb;
    import sbcip_pkg::*;
    localparam int UNIT = 2;
    logic i_sys_clk, i_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
    logic i_s_axi_arvalid, i_s_axi_rready, o_s_axi_awready, o_s_axi_wready;
    logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
    logic [3:0] i_s_axi_wstrb;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    logic i_spi_sclk, i_chip_select_n, i_spi_mosi, i_frame_bad_access, i_frame_secure_fail;
    logic i_init_phase, i_main_state, o_interrupt_out_n, o_irq, o_can_supply_en;
    sbcip_analog_type i_analog;
    int pulses, n_mismatch, n_compared, cyc, exp_p, s, k;
    sbcip_top #(.PULSE_UNIT_CYC(UNIT)) sbcip_top_i (.*);
    sbcip_host_model sbcip_host_model_i (.i_sys_clk(i_sys_clk),
        .i_interrupt_out_n(o_interrupt_out_n), .o_spi_sclk(i_spi_sclk),
        .o_chip_select_n(i_chip_select_n), .o_spi_mosi(i_spi_mosi), .o_pulse_cnt(pulses));
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge i_sys_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge i_sys_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
            if (o_s_axi_bvalid) begin
                done = 1'b1;
                i_s_axi_bready <= 1'b0;
                chk(32'(o_s_axi_bresp), 32'(er));
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge i_sys_clk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge i_sys_clk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
            if (o_s_axi_rvalid) begin
                done = 1'b1;
                i_s_axi_rready <= 1'b0;
                chk(o_s_axi_rdata, e);
                chk(32'(o_s_axi_rresp), 32'(er));
            end
        end
    endtask
    // Waits for one low pulse, checks its length
    task automatic pulse(input int len);
        int t, w;
        w = 0;
        for (t = 0; t < 100 && o_interrupt_out_n !== 1'b0; t++) @(negedge i_sys_clk);
        while (o_interrupt_out_n === 1'b0 && w < 600) begin
            w++;
            @(negedge i_sys_clk);
        end
        chk(32'(w), 32'(len));
        exp_p++;
    endtask
    // Reads, clears and rereads status
    task automatic status(input logic [31:0] e);
        rd(8'h00, e, 2'h0);
        wr(8'h00, e, 2'h0);
        rd(8'h00, 32'h0, 2'h0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 4'h0;
        {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 48'h0;
        {i_s_axi_rready, i_frame_bad_access, i_frame_secure_fail, i_main_state} = 4'h0;
        i_s_axi_wstrb = 4'hf;
        i_init_phase = 1'b1;
        i_analog = '0;
        i_rst = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h08, 32'h0000_0f01, 2'h0);
        wr(8'h08, 32'h0000_0101, 2'h0);
        rd(8'h08, 32'h0000_0101, 2'h0);
        for (s = 0; s < 25; s++) begin
            k = (s < 6) ? 20 + s : (s < 12) ? 8 + s : (s < 24) ? 25 - s : 0;
            @(posedge i_sys_clk);
            i_analog[k] <= 1'b1;
            pulse(2 * UNIT);
            rd(8'h00, 32'h1 << s, 2'h0);
            if (s == 20) rd(8'h10, 32'h0000_0380, 2'h0);
            @(posedge i_sys_clk);
            i_analog[k] <= 1'b0;
            repeat (8) @(posedge i_sys_clk);
            if (s == 23) begin
                chk(32'(o_can_supply_en), 32'h0);
                i_analog.can_tj_cooled <= 1'b1;
                repeat (8) @(posedge i_sys_clk);
                chk(32'(o_can_supply_en), 32'h1);
                i_analog.can_tj_cooled <= 1'b0;
            end
            status(32'h1 << s);
            chk(32'(pulses), 32'(exp_p));
        end
        wr(8'h04, 32'h1 << 25, 2'h0);
        wr(8'h0c, 32'h1, 2'h0);
        repeat (20) @(posedge i_sys_clk);
        chk(32'(pulses), 32'(exp_p));
        chk(32'(o_irq), 32'h0);
        status(32'h1 << 25);
        wr(8'h04, 32'h0, 2'h0);
        wr(8'h0c, 32'h1, 2'h0);
        pulse(2 * UNIT);
        chk(32'(o_irq), 32'h1);
        status(32'h1 << 25);
        wr(8'h08, 32'h0000_0100, 2'h0);
        i_init_phase <= 1'b0;
        wr(8'h08, 32'h0000_0f01, 2'h2);
        rd(8'h08, 32'h0000_0100, 2'h0);
        status(32'h1 << 28);
        wr(8'h40, 32'h1, 2'h2);
        rd(8'h40, 32'h0, 2'h2);
        i_main_state <= 1'b1;
        sbcip_host_model_i.send_frame(16'h0001, 15);
        status(32'h1 << 27);
        sbcip_host_model_i.send_frame(16'h0003, 16);
        status(32'h1 << 29);
        sbcip_host_model_i.send_frame(16'h0001, 16);
        rd(8'h00, 32'h0, 2'h0);
        i_frame_bad_access <= 1'b1;
        @(posedge i_sys_clk);
        i_frame_bad_access <= 1'b0;
        status(32'h1 << 28);
        i_frame_secure_fail <= 1'b1;
        @(posedge i_sys_clk);
        i_frame_secure_fail <= 1'b0;
        status(32'h1 << 26);
        chk(32'(pulses), 32'(exp_p));
        give_verdict();
    end
endmodule

// ---- hdl/sbcip_defs.svh ----
// Offsets, field positions, reset values and timing counts of the interrupt pulse unit
`ifndef SBCIP_DEFS_SVH
`define SBCIP_DEFS_SVH

// Register byte offsets
`define SBCIP_REG_STATUS 8'h00
`define SBCIP_REG_MASK 8'h04
`define SBCIP_REG_CONFIG 8'h08
`define SBCIP_REG_REQUEST 8'h0c
`define SBCIP_REG_STATE 8'h10

// Reset values
`define SBCIP_MASK_RST 32'h0000_0000
`define SBCIP_CFG_EN_RST 1'b1
`define SBCIP_CFG_LEN_RST 8'h0f

// Config register fields
`define SBCIP_CFG_EN_BIT 0
`define SBCIP_CFG_LEN_LSB 8
`define SBCIP_CFG_LEN_MSB 15

// Event bit positions in status and mask
`define SBCIP_EV_IO_CHG 0
`define SBCIP_EV_IO_WAKE 6
`define SBCIP_EV_CAN_WAKE 12
`define SBCIP_EV_LIN_WAKE 13
`define SBCIP_EV_CAN_FAULT 14
`define SBCIP_EV_LIN_FAULT 17
`define SBCIP_EV_PREREG 20
`define SBCIP_EV_AUX_LIM 21
`define SBCIP_EV_REF_LIM 22
`define SBCIP_EV_CAN_TSD 23
`define SBCIP_EV_REF_TSD 24
`define SBCIP_EV_INT_REQ 25
`define SBCIP_EV_SECURE 26
`define SBCIP_EV_CLK_CNT 27
`define SBCIP_EV_ACCESS 28
`define SBCIP_EV_PARITY 29
`define SBCIP_EV_NUM 30

// Serial frame
`define SBCIP_FRAME_BITS 5'h10

// Timing: one pulse length step
`define SBCIP_CLK_MHZ 250
`define SBCIP_PULSE_UNIT_NS 1000
`define SBCIP_PULSE_UNIT_CYC ((`SBCIP_PULSE_UNIT_NS * `SBCIP_CLK_MHZ) / 1000)

`endif

// ---- hdl/sbcip_pkg.sv ----
// Types shared by the interrupt pulse unit
package sbcip_pkg;

    // Raw levels from analog supervision and pin blocks, asynchronous
    typedef struct packed {
        logic [5:0] io_level;
        logic [5:0] config_pin_wake;
        logic can_bus_wake;
        logic lin_bus_wake;
        logic can_rx_stuck_recessive;
        logic can_tx_stuck_low;
        logic can_bus_stuck_dominant;
        logic lin_rx_stuck_recessive;
        logic lin_tx_stuck_low;
        logic lin_bus_stuck_dominant;
        logic prereg_topology_state;
        logic aux_limit_timeout;
        logic ref_limit_timeout;
        logic can_supply_thermal_shutdown;
        logic can_tj_cooled;
        logic ref_supply_thermal_shutdown;
    } sbcip_analog_type;

    // Pulse configuration
    typedef struct packed {
        logic [7:0] pulse_len;
        logic pulse_en;
    } sbcip_cfg_type;

    typedef enum logic [1:0] {
        SBCIP_IDLE = 2'b01,
        SBCIP_LOW = 2'b10
    } sbcip_state_type;

endpackage

// ---- hdl/sbcip_top.sv ----
// Interrupt pulse unit: event flags, mask, pulse output, frame checks, register slave
//
// Summary of operation
// R01 - Enabled event drives one low output pulse
// R02 - Pulse setup writable only during init phase
// R03 - Masked sources cause no pulse while masked; a flag still set pulses when its mask bit clears
// R04 - Main state: flag clock count not sixteen
// R05 - Flag malformed, unknown or late-init accesses
// R06 - Main state: flag frame parity mismatch
// R07 - Flag failed frame integrity check
// R08 - Host request command raises a pulse
// R09 - Each config pin level change flags
// R10 - Each config pin wake-up flags separately
// R11 - Separate CAN and LIN wake events
// R12 - Three separate CAN clamping fault events
// R13 - Three separate LIN clamping fault events
// R14 - Report pre-regulator buck or boost state
// R15 - Flag auxiliary current-limit duration expiry
// R16 - CAN supply restarts after cooling down
// R17 - Flag reference regulator thermal shutdown
// R18 - Sticky flags; pulse only on new assertion
`timescale 1ns/1ps
`include "sbcip_defs.svh"

module sbcip_top #(
    parameter int PULSE_UNIT_CYC = `SBCIP_PULSE_UNIT_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // AXI4-Lite slave
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // Serial interface pins, asynchronous
    input wire logic i_spi_sclk,
    input wire logic i_chip_select_n,
    input wire logic i_spi_mosi,
    // Frame decoder results, same clock
    input wire logic i_frame_bad_access,
    input wire logic i_frame_secure_fail,
    // Device phase, same clock
    input wire logic i_init_phase,
    input wire logic i_main_state,
    // Supervision sources, asynchronous
    input wire sbcip_pkg::sbcip_analog_type i_analog,
    // Outputs
    output logic o_interrupt_out_n,
    output logic o_irq,
    output logic o_can_supply_en
);
    import sbcip_pkg::*;

    localparam int AW = $bits(sbcip_analog_type);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Synchronisers

    logic [AW-1:0] an_s1;
    logic [AW-1:0] an_s2;
    logic [AW-1:0] an_s3;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            an_s1 <= '0;
            an_s2 <= '0;
            an_s3 <= '0;
        end else begin
            an_s1 <= i_analog;
            an_s2 <= an_s1;
            an_s3 <= an_s2;
        end
    end

    // Chip select idles high
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1 <= 3'h2;
            pin_s2 <= 3'h2;
            pin_s3 <= 3'h2;
        end else begin
            pin_s1 <= {i_spi_mosi, i_chip_select_n, i_spi_sclk};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    sbcip_analog_type an_now;
    sbcip_analog_type an_old;
    assign an_now = an_s2;
    assign an_old = an_s3;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Serial frame monitor

    logic sclk_rise;
    logic cs_rise;
    logic cs_low;
    logic [4:0] edge_cnt;
    logic [15:0] frame_bits;
    logic ev_clk_cnt;
    logic ev_parity;

    assign sclk_rise = pin_s2[0] & ~pin_s3[0];
    assign cs_low = ~pin_s2[1];
    assign cs_rise = pin_s2[1] & ~pin_s3[1];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            edge_cnt <= 5'h00;
            frame_bits <= 16'h0000;
        end else if (cs_low && sclk_rise) begin
            if (edge_cnt != 5'h1f) begin
                edge_cnt <= edge_cnt + 5'h01;
            end
            frame_bits <= {frame_bits[14:0], pin_s2[2]};
        end else if (cs_rise) begin
            edge_cnt <= 5'h00;
        end
    end

    // Frame checks at the end of each chip select low phase in main state
    always_comb begin
        ev_clk_cnt = cs_rise && i_main_state && (edge_cnt != `SBCIP_FRAME_BITS); // R04
        ev_parity = cs_rise && i_main_state && (edge_cnt == `SBCIP_FRAME_BITS)
            && !(^frame_bits); // R06
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic wr_hit;
    logic wr_cfg_late;

    assign wr_go = aw_have && w_have && !o_s_axi_bvalid;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_have <= 1'b0;
            aw_addr <= 8'h00;
            o_s_axi_awready <= 1'b0;
        end else if (o_s_axi_awready && i_s_axi_awvalid) begin
            aw_have <= 1'b1;
            aw_addr <= i_s_axi_awaddr;
            o_s_axi_awready <= 1'b0;
        end else if (wr_go) begin
            aw_have <= 1'b0;
        end else if (!aw_have && !o_s_axi_bvalid) begin
            o_s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            w_have <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            o_s_axi_wready <= 1'b0;
        end else if (o_s_axi_wready && i_s_axi_wvalid) begin
            w_have <= 1'b1;
            w_data <= i_s_axi_wdata;
            w_strb <= i_s_axi_wstrb;
            o_s_axi_wready <= 1'b0;
        end else if (wr_go) begin
            w_have <= 1'b0;
        end else if (!w_have && !o_s_axi_bvalid) begin
            o_s_axi_wready <= 1'b1;
        end
    end

    always_comb begin
        wr_hit = (aw_addr == `SBCIP_REG_STATUS) || (aw_addr == `SBCIP_REG_MASK)
            || (aw_addr == `SBCIP_REG_CONFIG) || (aw_addr == `SBCIP_REG_REQUEST);
        wr_cfg_late = wr_go && (aw_addr == `SBCIP_REG_CONFIG) && !i_init_phase; // R02
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= 2'h0;
        end else if (wr_go) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= (wr_hit && !wr_cfg_late) ? 2'h0 : 2'h2;
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Registers and events

    logic [31:0] status;
    logic [31:0] mask;
    sbcip_cfg_type cfg;
    logic [31:0] wmask;
    logic [31:0] ev;
    logic [31:0] clr;
    logic host_req;

    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mask <= `SBCIP_MASK_RST;
        end else if (wr_go && aw_addr == `SBCIP_REG_MASK) begin
            mask <= (mask & ~wmask) | (w_data & wmask); // R03
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg.pulse_en <= `SBCIP_CFG_EN_RST;
            cfg.pulse_len <= `SBCIP_CFG_LEN_RST;
        end else if (wr_go && aw_addr == `SBCIP_REG_CONFIG && i_init_phase) begin // R02
            if (w_strb[0]) begin
                cfg.pulse_en <= w_data[`SBCIP_CFG_EN_BIT];
            end
            if (w_strb[1]) begin
                cfg.pulse_len <= w_data[`SBCIP_CFG_LEN_MSB:`SBCIP_CFG_LEN_LSB];
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            host_req <= 1'b0;
        end else begin
            host_req <= wr_go && (aw_addr == `SBCIP_REG_REQUEST) && w_strb[0] && w_data[0]; // R08
        end
    end

    always_comb begin
        ev = 32'h0000_0000;
        ev[`SBCIP_EV_IO_CHG +: 6] = an_now.io_level ^ an_old.io_level; // R09
        ev[`SBCIP_EV_IO_WAKE +: 6] = an_now.config_pin_wake & ~an_old.config_pin_wake; // R10
        ev[`SBCIP_EV_CAN_WAKE] = an_now.can_bus_wake & ~an_old.can_bus_wake; // R11
        ev[`SBCIP_EV_LIN_WAKE] = an_now.lin_bus_wake & ~an_old.lin_bus_wake; // R11
        ev[`SBCIP_EV_CAN_FAULT] = an_now.can_rx_stuck_recessive
            & ~an_old.can_rx_stuck_recessive; // R12
        ev[`SBCIP_EV_CAN_FAULT + 1] = an_now.can_tx_stuck_low & ~an_old.can_tx_stuck_low; // R12
        ev[`SBCIP_EV_CAN_FAULT + 2] = an_now.can_bus_stuck_dominant
            & ~an_old.can_bus_stuck_dominant; // R12
        ev[`SBCIP_EV_LIN_FAULT] = an_now.lin_rx_stuck_recessive
            & ~an_old.lin_rx_stuck_recessive; // R13
        ev[`SBCIP_EV_LIN_FAULT + 1] = an_now.lin_tx_stuck_low & ~an_old.lin_tx_stuck_low; // R13
        ev[`SBCIP_EV_LIN_FAULT + 2] = an_now.lin_bus_stuck_dominant
            & ~an_old.lin_bus_stuck_dominant; // R13
        ev[`SBCIP_EV_PREREG] = an_now.prereg_topology_state
            ^ an_old.prereg_topology_state; // R14
        ev[`SBCIP_EV_AUX_LIM] = an_now.aux_limit_timeout & ~an_old.aux_limit_timeout; // R15
        ev[`SBCIP_EV_REF_LIM] = an_now.ref_limit_timeout & ~an_old.ref_limit_timeout;
        ev[`SBCIP_EV_CAN_TSD] = an_now.can_supply_thermal_shutdown
            & ~an_old.can_supply_thermal_shutdown;
        ev[`SBCIP_EV_REF_TSD] = an_now.ref_supply_thermal_shutdown
            & ~an_old.ref_supply_thermal_shutdown; // R17
        ev[`SBCIP_EV_INT_REQ] = host_req; // R08
        ev[`SBCIP_EV_SECURE] = i_frame_secure_fail; // R07
        ev[`SBCIP_EV_CLK_CNT] = ev_clk_cnt; // R04
        ev[`SBCIP_EV_ACCESS] = i_frame_bad_access || wr_cfg_late; // R05
        ev[`SBCIP_EV_PARITY] = ev_parity; // R06
    end

    assign clr = (wr_go && aw_addr == `SBCIP_REG_STATUS) ? (w_data & wmask) : 32'h0000_0000;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            status <= 32'h0000_0000;
        end else begin
            status <= (status & ~clr) | ev; // R18
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // CAN supply thermal restart

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_can_supply_en <= 1'b1;
        end else if (an_now.can_supply_thermal_shutdown) begin
            o_can_supply_en <= 1'b0;
        end else if (!o_can_supply_en && an_now.can_tj_cooled) begin
            o_can_supply_en <= 1'b1; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pulse generator

    logic [31:0] active;
    logic [31:0] active_old;
    logic fresh;
    sbcip_state_type state;
    logic [15:0] pulse_cnt;
    logic [15:0] pulse_cyc;

    assign active = status & ~mask; // R03
    assign fresh = |(active & ~active_old); // R18
    assign pulse_cyc = 16'(({8'h00, cfg.pulse_len} + 16'h0001) * 16'(PULSE_UNIT_CYC));

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            active_old <= 32'h0000_0000;
            o_irq <= 1'b0;
        end else begin
            active_old <= active;
            o_irq <= |active;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= SBCIP_IDLE;
            pulse_cnt <= 16'h0000;
            o_interrupt_out_n <= 1'b1;
        end else begin
            case (state)
                SBCIP_IDLE: begin
                    if (fresh && cfg.pulse_en) begin
                        state <= SBCIP_LOW;
                        pulse_cnt <= pulse_cyc - 16'h0001;
                        o_interrupt_out_n <= 1'b0; // R01
                    end
                end
                SBCIP_LOW: begin
                    if (pulse_cnt == 16'h0000) begin
                        state <= SBCIP_IDLE;
                        o_interrupt_out_n <= 1'b1; // R01
                    end else begin
                        pulse_cnt <= pulse_cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= SBCIP_IDLE;
                    o_interrupt_out_n <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (i_s_axi_araddr)
            `SBCIP_REG_STATUS: rd_word = status;
            `SBCIP_REG_MASK: rd_word = mask;
            `SBCIP_REG_CONFIG: rd_word = {16'h0000, cfg.pulse_len, 7'h00, cfg.pulse_en};
            `SBCIP_REG_REQUEST: rd_word = 32'h0000_0000;
            `SBCIP_REG_STATE: rd_word = {21'h000000, state == SBCIP_LOW, i_init_phase,
                o_can_supply_en, an_now.prereg_topology_state, 1'b0, an_now.io_level}; // R14
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= 2'h0;
        end else if (o_s_axi_arready && i_s_axi_arvalid) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= rd_word;
            o_s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
        end else if (o_s_axi_rvalid) begin
            if (i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end else begin
            o_s_axi_arready <= 1'b1;
        end
    end

endmodule
